// *** dwd_pkg.sv ***
// Purpose: Shared constants and types for the dual wiper command decoder
// Assumes: 16-bit frames, two channels with two string registers each
// Notes:   Operation list below is numbered as used in the design files
`default_nettype none
package dwd_pkg;

	localparam int          DWD_WIPER_W    = 8;
	localparam int          DWD_ENTRIES    = 4;
	localparam int          DWD_FRAME_BITS = 16;

	// Frame field positions
	localparam int          DWD_CMD_MSB    = 15;
	localparam int          DWD_ADDR_MSB   = 11;
	localparam int          DWD_DATA_MSB   = 7;

	// Address bits
	localparam int          DWD_A_BCAST    = 3;
	localparam int          DWD_A_STRING   = 2;
	localparam int          DWD_A_CHAN     = 0;

	// Control register fields and reset value
	localparam int          DWD_CTL_WP     = 0;
	localparam int          DWD_CTL_NVEN   = 1;
	localparam int          DWD_CTL_LIN    = 2;
	localparam logic [2:0]  DWD_CTL_RESET  = 3'h3;

	// Nonvolatile cells leave the factory at midscale
	localparam logic [7:0]  DWD_NV_RESET   = 8'h80;

	// Readback selectors
	localparam logic [1:0]  DWD_RB_PRE     = 2'h0;
	localparam logic [1:0]  DWD_RB_NV      = 2'h1;
	localparam logic [1:0]  DWD_RB_CTL     = 2'h2;
	localparam logic [1:0]  DWD_RB_WIPER   = 2'h3;

	// Scale and shutdown data patterns, bits 7:1
	localparam logic [6:0]  DWD_TS_PAT     = 7'h40;
	localparam logic [6:0]  DWD_ZERO_PAT   = 7'h00;

	// Reload time
	localparam int          DWD_CLK_KHZ    = 10000;
	localparam int          DWD_RELOAD_US  = 30;
	localparam int          DWD_RELOAD_CYC =
		(DWD_RELOAD_US * DWD_CLK_KHZ) / 1000;
	localparam int          DWD_CNT_W      = 12;

	typedef enum logic [3:0] {
		DWD_OP_NOP    = 4'h0,
		DWD_OP_WIPER  = 4'h1,
		DWD_OP_PRE    = 4'h2,
		DWD_OP_READ   = 4'h3,
		DWD_OP_STEP   = 4'h4,
		DWD_OP_SHIFT  = 4'h5,
		DWD_OP_XFER   = 4'h6,
		DWD_OP_NVCOPY = 4'h7,
		DWD_OP_NVWR   = 4'h8,
		DWD_OP_SCALE  = 4'h9,
		DWD_OP_SWRST  = 4'hB,
		DWD_OP_SHDN   = 4'hC,
		DWD_OP_CTRL   = 4'hD
	} dwd_op_t;

	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] addr;
		logic [7:0] data;
	} dwd_frame_t;

	typedef enum logic [0:0] {
		DWD_ST_RUN    = 1'b0,
		DWD_ST_RELOAD = 1'b1
	} dwd_state_t;

endpackage : dwd_pkg
`default_nettype wire

// *** dwd_spi_port.sv ***
// Purpose: Serial frame receiver and readback shifter
// Assumes: sclk, cs_n and sdi synchronous to clk_sys, sclk much slower
// Notes:   Only frames of exactly 16 bits are delivered
`timescale 1ns/100ps
`default_nettype none
module dwd_spi_port
	import dwd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        sdi,
	input  wire logic [15:0] tx_word,
	output logic             frame_valid,
	output dwd_frame_t       frame,
	output logic             sdo
);

	logic        sclk_q;
	logic        cs_n_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic [4:0]  cnt_q;
	logic        valid_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= sclk;
			cs_n_q <= cs_n;
		end
	end

	// Sample on rising sclk, MSB first
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_q  <= 16'h0000;
			cnt_q <= 5'h00;
		end else if (cs_n) begin
			cnt_q <= 5'h00;
		end else if (sclk && !sclk_q) begin
			rx_q <= {rx_q[14:0], sdi};
			if (cnt_q != 5'h1F)
				cnt_q <= cnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			valid_q <= 1'b0;
		else
			valid_q <= cs_n && !cs_n_q &&
				(cnt_q == 5'(DWD_FRAME_BITS));
	end

	// Readback leaves during the frame after the request
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tx_q <= 16'h0000;
		end else if (!cs_n && cs_n_q) begin
			tx_q <= tx_word;
		end else if (!cs_n && !sclk && sclk_q) begin
			tx_q <= {tx_q[14:0], 1'b0};
		end
	end

	assign frame_valid = valid_q;
	assign frame       = dwd_frame_t'(rx_q);
	assign sdo         = tx_q[15];

endmodule : dwd_spi_port
`default_nettype wire

// *** dwd_nv_cells.sv ***
// Purpose: Nonvolatile wiper store, one cell per string register
// Assumes: programming time is not modelled
// Notes:   Cells start at midscale after reset
`timescale 1ns/100ps
`default_nettype none
module dwd_nv_cells
	import dwd_pkg::*;
#(
	parameter int W = DWD_WIPER_W
)(
	input  wire logic                      clk_sys,
	input  wire logic                      rstn,
	input  wire logic                      wr_en,
	input  wire logic [1:0]                wr_idx,
	input  wire logic [W-1:0]              wr_data,
	output logic      [DWD_ENTRIES*W-1:0]  cells
);

	logic [W-1:0] mem_q [DWD_ENTRIES];

	generate
		for (genvar i = 0; i < DWD_ENTRIES; i++) begin : g_cell
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					mem_q[i] <= W'(DWD_NV_RESET);
				else if (wr_en && (wr_idx == 2'(i)))
					mem_q[i] <= wr_data;
			end
			assign cells[i*W +: W] = mem_q[i];
		end
	endgenerate

endmodule : dwd_nv_cells
`default_nettype wire

// *** dwd_decoder.sv ***
// Purpose: Command decoder and register file of a dual wiper controller
// Assumes: entry index is {channel, upper string}; nv cell index the same
// Notes:   Frames arriving during a reload are dropped
`timescale 1ns/100ps
`default_nettype none
module dwd_decoder
	import dwd_pkg::*;
#(
	parameter int W = DWD_WIPER_W
)(
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          sclk,
	input  wire logic          cs_n,
	input  wire logic          sdi,
	input  wire logic          reset_pin_n,
	input  wire logic          power_up_mode_pin,
	output logic               sdo,
	output logic [2*W-1:0]     lower_string_setting,
	output logic [2*W-1:0]     upper_string_setting,
	output logic [1:0]         top_scale,
	output logic [1:0]         bottom_scale,
	output logic [1:0]         shutdown,
	output logic               linear_mode,
	output logic               reload_busy
);

	localparam logic [W-1:0] FULL = {W{1'b1}};
	localparam logic [W-1:0] ONE  = W'(1);

	dwd_frame_t               frame;
	logic                     frame_valid;
	logic                     spi_sdo;
	logic [15:0]              rb_q;
	logic [DWD_ENTRIES*W-1:0] nv;
	logic                     nv_wr;
	logic [1:0]               nv_idx;
	logic [W-1:0]             nv_data;

	dwd_state_t               state_q;
	logic [DWD_CNT_W-1:0]     cnt_q;
	logic                     reload_done;
	logic [2:0]               ctl_q;
	logic                     lin;
	logic                     go;
	logic                     wp_ok;
	logic                     nv_ok;
	logic [DWD_ENTRIES-1:0]   tgt;
	logic [1:0]               single;
	logic [1:0]               chan_hit;
	logic [1:0]               chan_ld;
	logic [W-1:0]             wiper_q [DWD_ENTRIES];
	logic [W-1:0]             pre_q   [DWD_ENTRIES];
	logic [W-1:0]             wiper_d [DWD_ENTRIES];
	logic [DWD_ENTRIES-1:0]   wiper_ld;
	logic [1:0]               ts_q;
	logic [1:0]               bs_q;
	logic [1:0]               sd_q;
	logic                     lin_q;
	logic [2*W-1:0]           lower_q;
	logic [2*W-1:0]           upper_q;
	logic                     sdo_q;

	dwd_spi_port u_spi (
		.clk_sys     (clk_sys),
		.rstn        (rstn),
		.sclk        (sclk),
		.cs_n        (cs_n),
		.sdi         (sdi),
		.tx_word     (rb_q),
		.frame_valid (frame_valid),
		.frame       (frame),
		.sdo         (spi_sdo)
	);

	dwd_nv_cells #(.W(W)) u_nv (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.wr_en   (nv_wr),
		.wr_idx  (nv_idx),
		.wr_data (nv_data),
		.cells   (nv)
	);

	assign lin   = power_up_mode_pin | ctl_q[DWD_CTL_LIN];
	assign go    = frame_valid && (state_q == DWD_ST_RUN);
	assign wp_ok = ctl_q[DWD_CTL_WP];
	assign nv_ok = ctl_q[DWD_CTL_NVEN];

	// Upper string is reachable only in linear gain mode
	assign single = {frame.addr[DWD_A_CHAN],
		frame.addr[DWD_A_STRING] & lin};

	always_comb begin
		tgt = '0;
		if (frame.addr[DWD_A_BCAST])
			tgt = lin ? 4'hF : 4'h5;
		else
			tgt[single] = 1'b1;
	end

	// Power-on preset, software reset and reset pin share one sequence
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= DWD_ST_RELOAD;
			cnt_q   <= '0;
		end else if (!reset_pin_n ||
			(go && frame.cmd == DWD_OP_SWRST)) begin
			state_q <= DWD_ST_RELOAD;
			cnt_q   <= '0;
		end else if (state_q == DWD_ST_RELOAD) begin
			if (reload_done)
				state_q <= DWD_ST_RUN;
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign reload_done = (state_q == DWD_ST_RELOAD) &&
		(cnt_q == DWD_CNT_W'(DWD_RELOAD_CYC - 1));

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			ctl_q <= DWD_CTL_RESET;
		else if (go && frame.cmd == DWD_OP_CTRL)
			ctl_q <= frame.data[2:0];
	end

	// Wiper, preload and step arithmetic, one copy per string register
	generate
		for (genvar i = 0; i < DWD_ENTRIES; i++) begin : g_ent
			logic [W-1:0] cur;
			assign cur = wiper_q[i];

			always_comb begin
				wiper_d[i]  = cur;
				wiper_ld[i] = 1'b0;
				if (reload_done) begin
					wiper_d[i]  = nv[i*W +: W];
					wiper_ld[i] = 1'b1;
				end else if (go && tgt[i]) begin
					case (frame.cmd)
						DWD_OP_WIPER: begin
							wiper_d[i]  = W'(frame.data);
							wiper_ld[i] = wp_ok;
						end
						DWD_OP_STEP: begin
							if (frame.data[0])
								wiper_d[i] = (cur == FULL) ? cur
									: cur + ONE;
							else
								wiper_d[i] = (cur == '0) ? cur
									: cur - ONE;
							wiper_ld[i] = wp_ok;
						end
						DWD_OP_SHIFT: begin
							if (!frame.data[0])
								wiper_d[i] = cur >> 1;
							else if (cur == '0)
								wiper_d[i] = ONE;
							else if (cur[W-1])
								wiper_d[i] = FULL;
							else
								wiper_d[i] = cur << 1;
							wiper_ld[i] = wp_ok;
						end
						DWD_OP_XFER: begin
							wiper_d[i]  = pre_q[i];
							wiper_ld[i] = wp_ok;
						end
						DWD_OP_NVCOPY: begin
							wiper_d[i]  = nv[i*W +: W];
							wiper_ld[i] = !frame.data[0];
						end
						default: begin
							wiper_d[i]  = cur;
							wiper_ld[i] = 1'b0;
						end
					endcase
				end
			end

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					wiper_q[i] <= W'(DWD_NV_RESET);
				else if (wiper_ld[i])
					wiper_q[i] <= wiper_d[i];
			end

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					pre_q[i] <= W'(DWD_NV_RESET);
				else if (wiper_ld[i])
					pre_q[i] <= wiper_d[i];
				else if (go && frame.cmd == DWD_OP_PRE &&
					!frame.addr[DWD_A_BCAST] && single == 2'(i))
					pre_q[i] <= W'(frame.data);
			end
		end
	endgenerate

	// Nonvolatile writes: store of a wiper, or direct data write
	always_comb begin
		nv_wr   = 1'b0;
		nv_idx  = single;
		nv_data = wiper_q[single];
		if (go && nv_ok) begin
			if (frame.cmd == DWD_OP_NVCOPY && frame.data[0] &&
				!frame.addr[DWD_A_BCAST]) begin
				nv_wr = 1'b1;
			end else if (frame.cmd == DWD_OP_NVWR &&
				frame.addr[3:2] == 2'h0) begin
				nv_wr   = 1'b1;
				nv_idx  = frame.addr[1:0];
				nv_data = W'(frame.data);
			end
		end
	end

	// Scale and shutdown are per channel; stored wipers stay untouched
	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			assign chan_hit[c] = tgt[2*c] | tgt[2*c+1];
			assign chan_ld[c]  = wiper_ld[2*c] | wiper_ld[2*c+1];

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					sd_q[c] <= 1'b0;
				end else if (reload_done) begin
					sd_q[c] <= 1'b0;
				end else if (go && chan_hit[c] &&
					frame.cmd == DWD_OP_SHDN &&
					frame.data[7:1] == DWD_ZERO_PAT) begin
					sd_q[c] <= frame.data[0];
				end
			end

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					ts_q[c] <= 1'b0;
					bs_q[c] <= 1'b0;
				end else if (chan_ld[c]) begin
					ts_q[c] <= 1'b0;
					bs_q[c] <= 1'b0;
				end else if (go && chan_hit[c]) begin
					if (frame.cmd == DWD_OP_SHDN && frame.data[0] &&
						frame.data[7:1] == DWD_ZERO_PAT) begin
						ts_q[c] <= 1'b0;
						bs_q[c] <= 1'b0;
					end else if (frame.cmd == DWD_OP_SCALE &&
						frame.data[7:1] == DWD_TS_PAT) begin
						ts_q[c] <= frame.data[0];
						if (frame.data[0])
							bs_q[c] <= 1'b0;
					end else if (frame.cmd == DWD_OP_SCALE &&
						frame.data[7:1] == DWD_ZERO_PAT) begin
						bs_q[c] <= frame.data[0];
						if (frame.data[0])
							ts_q[c] <= 1'b0;
					end
				end
			end

			// Protection shows the stored value, not the live register
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					lower_q[c*W +: W] <= W'(DWD_NV_RESET);
					upper_q[c*W +: W] <= W'(DWD_NV_RESET);
				end else if (ctl_q[DWD_CTL_WP]) begin
					lower_q[c*W +: W] <= wiper_q[2*c];
					upper_q[c*W +: W] <= wiper_q[2*c+1];
				end else begin
					lower_q[c*W +: W] <= nv[2*c*W +: W];
					upper_q[c*W +: W] <= nv[(2*c+1)*W +: W];
				end
			end
		end
	endgenerate

	// Readback word is latched now, shifted out in the next frame
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rb_q <= 16'h0000;
		end else if (go && frame.cmd == DWD_OP_READ) begin
			case (frame.data[1:0])
				DWD_RB_PRE:   rb_q <= 16'(pre_q[single]);
				DWD_RB_NV:    rb_q <= 16'(nv[frame.addr[1:0]*W +: W]);
				DWD_RB_CTL:   rb_q <= 16'(ctl_q);
				DWD_RB_WIPER: rb_q <= 16'(wiper_q[single]);
				default:      rb_q <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lin_q <= 1'b0;
			sdo_q <= 1'b0;
		end else begin
			lin_q <= lin;
			sdo_q <= spi_sdo;
		end
	end

	assign sdo                  = sdo_q;
	assign lower_string_setting = lower_q;
	assign upper_string_setting = upper_q;
	assign top_scale            = ts_q;
	assign bottom_scale         = bs_q;
	assign shutdown             = sd_q;
	assign linear_mode          = lin_q;
	assign reload_busy          = (state_q == DWD_ST_RELOAD);

endmodule : dwd_decoder
`default_nettype wire

// *** dwd_decoder_chk.sv ***
// Purpose: Port checker for the dual wiper command decoder
// Assumes: one clock domain, clk_sys
// Notes:   Bound to every dwd_decoder instance
`timescale 1ns/100ps
`default_nettype none
module dwd_decoder_chk
	import dwd_pkg::*;
#(
	parameter int W = DWD_WIPER_W
)(
	input wire logic           clk_sys,
	input wire logic           rstn,
	input wire logic           cs_n,
	input wire logic           reset_pin_n,
	input wire logic           power_up_mode_pin,
	input wire logic [2*W-1:0] lower_string_setting,
	input wire logic [2*W-1:0] upper_string_setting,
	input wire logic [1:0]     top_scale,
	input wire logic [1:0]     bottom_scale,
	input wire logic [1:0]     shutdown,
	input wire logic           linear_mode,
	input wire logic           reload_busy
);
	logic        cs_n_q;
	logic [3:0]  rise_cnt_q;
	logic [3:0]  rel_cnt_q;
	logic [11:0] busy_cnt_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cs_n_q     <= 1'b1;
			rise_cnt_q <= 4'hF;
			rel_cnt_q  <= 4'h0;
			busy_cnt_q <= 12'h000;
		end else begin
			cs_n_q     <= cs_n;
			rise_cnt_q <= (cs_n & ~cs_n_q) ? 4'h0 :
				((&rise_cnt_q) ? rise_cnt_q : rise_cnt_q + 4'h1);
			rel_cnt_q  <= reload_busy ? 4'h0 :
				((&rel_cnt_q) ? rel_cnt_q : rel_cnt_q + 4'h1);
			// Pin restart begins a fresh reload count
			busy_cnt_q <= (!reload_busy || !reset_pin_n) ? 12'h000 :
				busy_cnt_q + 12'h001;
		end
	end
	a_reload_len:
	assert property (busy_cnt_q <= DWD_RELOAD_CYC + 3)
		else $error("reload ran too long");
	a_pin_restart:
	assert property (!reset_pin_n |-> ##[1:2] reload_busy)
		else $error("reset pin did not start reload");
	a_quiet_frame:
	assert property ((!cs_n && !reload_busy) [*6] |->
		$stable(lower_string_setting) && $stable(upper_string_setting))
		else $error("setting changed inside a frame");
	a_change_cause:
	assert property (($changed(lower_string_setting) ||
		$changed(upper_string_setting)) |->
		(rise_cnt_q <= 4'h5 || rel_cnt_q <= 4'h5))
		else $error("setting changed without a frame");
	a_mode_or:
	assert property (power_up_mode_pin |=> linear_mode)
		else $error("mode pin not seen in mode");
	a_scale_excl:
	assert property ((top_scale & bottom_scale) == 2'b00)
		else $error("top and bottom scale together");
	a_shdn_scale:
	assert property ($rose(shutdown[1]) |->
		##[0:1] (!top_scale[1] && !bottom_scale[1]))
		else $error("scale kept in shutdown");
	a_reload_shdn:
	assert property ($fell(reload_busy) |-> ##[0:1] shutdown == 2'b00)
		else $error("shutdown kept over reload");
endmodule : dwd_decoder_chk

bind dwd_decoder dwd_decoder_chk #(.W(W)) u_chk (
	.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n),
	.reset_pin_n(reset_pin_n), .power_up_mode_pin(power_up_mode_pin),
	.lower_string_setting(lower_string_setting),
	.upper_string_setting(upper_string_setting),
	.top_scale(top_scale), .bottom_scale(bottom_scale),
	.shutdown(shutdown), .linear_mode(linear_mode),
	.reload_busy(reload_busy)
);
`default_nettype wire

// *** dwd_host.sv ***
// Purpose: Serial host model sending whole frames to the decoder
// Assumes: four clk_sys cycles per serial clock phase
// Notes:   Serial clock stands low between frames
`timescale 1ns/100ps
`default_nettype none
module dwd_host (
	input  wire logic clk_sys,
	input  wire logic sdo,
	output var logic  sclk,
	output var logic  cs_n,
	output wire logic sdi
);
	logic tog_q = 1'b0;
	logic bit_q = 1'b0;
	// Idle data toggles so a stale bit is never mistaken for data
	always @(posedge clk_sys) tog_q <= ~tog_q;
	assign sdi = cs_n ? tog_q : bit_q;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		tick(1);
		cs_n = 1'b0;
		tick(4);
		for (int i = 15; i >= 0; i--) begin
			bit_q = w[i];
			tick(4);
			r[i] = sdo;
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
		end
		tick(4);
		cs_n = 1'b1;
		// Gap also lets the outputs settle
		tick(6);
	endtask : xfer
endmodule : dwd_host
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the dual wiper command decoder
// Assumes: host model sends whole 16-bit frames
// Notes:   Expected values follow the command sequence by hand
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        reset_pin_n = 1'b1;
	logic        power_up_mode_pin = 1'b0;
	wire logic   sclk;
	wire logic   cs_n;
	wire logic   sdi;
	wire logic   sdo;
	logic [15:0] lower_string_setting;
	logic [15:0] upper_string_setting;
	logic [1:0]  top_scale;
	logic [1:0]  bottom_scale;
	logic [1:0]  shutdown;
	logic        linear_mode;
	logic        reload_busy;
	logic [15:0] v;
	logic [15:0] flags;
	int          error_cnt = 0;
	int          samples_checked = 0;
	dwd_decoder dut (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .reset_pin_n(reset_pin_n),
		.power_up_mode_pin(power_up_mode_pin), .sdo(sdo),
		.lower_string_setting(lower_string_setting),
		.upper_string_setting(upper_string_setting),
		.top_scale(top_scale), .bottom_scale(bottom_scale),
		.shutdown(shutdown), .linear_mode(linear_mode),
		.reload_busy(reload_busy));
	dwd_host u_host (.clk_sys(clk_sys), .sdo(sdo), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi));
	always #50 clk_sys = ~clk_sys;
	assign flags = {10'h0, top_scale, bottom_scale, shutdown};
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic frm(input logic [3:0] c, a, input logic [7:0] d);
		logic [15:0] r;
		u_host.xfer({c, a, d}, r);
	endtask : frm
	task automatic rd(input logic [3:0] a, input logic [1:0] s);
		frm(4'h3, a, {6'h00, s});
		u_host.xfer(16'h0000, v);
	endtask : rd
	task automatic wait_idle();
		int n;
		n = 0;
		// Reload lasts 300 cycles; 400 leaves margin
		while (reload_busy !== 1'b0 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		u_host.tick(4);
		chk({15'h0, reload_busy}, 16'h0000);
	endtask : wait_idle
	task automatic t_reset();
		wait_idle();
		chk(lower_string_setting, 16'h8080);
		chk({15'h0, linear_mode}, 16'h0000);
		rd(4'h0, 2'h2);
		chk(v, 16'h0003);
		$display("test reset done");
	endtask : t_reset
	task automatic t_write();
		frm(4'h1, 4'h0, 8'h12);
		frm(4'h1, 4'h1, 8'h34);
		chk(lower_string_setting, 16'h3412);
		rd(4'h0, 2'h0);
		chk(v, 16'h0012);
		frm(4'h2, 4'h0, 8'h55);
		chk(lower_string_setting, 16'h3412);
		rd(4'h0, 2'h0);
		chk(v, 16'h0055);
		frm(4'h6, 4'h0, 8'hA5);
		chk(lower_string_setting, 16'h3455);
		rd(4'h0, 2'h3);
		chk(v, 16'h0055);
		$display("test write done");
	endtask : t_write
	task automatic t_step();
		frm(4'h4, 4'h0, 8'h01);
		frm(4'h4, 4'h0, 8'h00);
		frm(4'h4, 4'h8, 8'h01);
		chk(lower_string_setting, 16'h3556);
		frm(4'h5, 4'h0, 8'h01);
		chk(lower_string_setting, 16'h35AC);
		frm(4'h5, 4'h0, 8'h01);
		chk(lower_string_setting, 16'h35FF);
		frm(4'h5, 4'h8, 8'h00);
		chk(lower_string_setting, 16'h1A7F);
		$display("test step done");
	endtask : t_step
	task automatic t_nv();
		frm(4'h7, 4'h0, 8'h01);
		rd(4'h0, 2'h1);
		chk(v, 16'h007F);
		frm(4'h1, 4'h0, 8'h01);
		frm(4'h7, 4'h0, 8'h00);
		chk(lower_string_setting, 16'h1A7F);
		frm(4'h8, 4'h1, 8'h66);
		frm(4'h8, 4'h4, 8'h77);
		rd(4'h1, 2'h1);
		chk(v, 16'h0066);
		rd(4'h0, 2'h1);
		chk(v, 16'h007F);
		$display("test nv done");
	endtask : t_nv
	task automatic t_scale();
		frm(4'h9, 4'h0, 8'h81);
		frm(4'h9, 4'h1, 8'h01);
		chk(flags, 16'h0018);
		frm(4'h9, 4'h0, 8'h80);
		chk(flags, 16'h0008);
		frm(4'h9, 4'h0, 8'h81);
		frm(4'h4, 4'h0, 8'h01);
		chk(flags, 16'h0008);
		chk(lower_string_setting, 16'h1A80);
		frm(4'hC, 4'h1, 8'h01);
		chk(flags, 16'h0002);
		frm(4'h1, 4'h1, 8'h22);
		chk(lower_string_setting, 16'h2280);
		frm(4'hC, 4'h1, 8'h00);
		chk(flags, 16'h0000);
		// Entering top scale must drop a standing bottom scale
		frm(4'h9, 4'h1, 8'h01);
		frm(4'h9, 4'h1, 8'h81);
		chk(flags, 16'h0020);
		frm(4'h9, 4'h1, 8'h80);
		chk(flags, 16'h0000);
		$display("test scale done");
	endtask : t_scale
	task automatic t_protect();
		frm(4'hD, 4'h0, 8'h02);
		rd(4'h0, 2'h2);
		chk(v, 16'h0002);
		chk(lower_string_setting, 16'h807F);
		// Refused write on the other channel leaves its old value, seen once writes are enabled again
		frm(4'h1, 4'h1, 8'h11);
		frm(4'h7, 4'h0, 8'h00);
		frm(4'hD, 4'hF, 8'hF9);
		chk(lower_string_setting, 16'h227F);
		frm(4'h8, 4'h0, 8'h22);
		rd(4'h0, 2'h1);
		chk(v, 16'h007F);
		frm(4'hD, 4'h0, 8'h05);
		chk({15'h0, linear_mode}, 16'h0001);
		frm(4'h1, 4'h4, 8'h44);
		chk({8'h00, upper_string_setting[7:0]}, 16'h0044);
		frm(4'hD, 4'h0, 8'h03);
		chk({15'h0, linear_mode}, 16'h0000);
		$display("test protect done");
	endtask : t_protect
	task automatic t_reload();
		frm(4'h1, 4'h0, 8'h09);
		frm(4'hC, 4'h0, 8'h01);
		chk(flags, 16'h0001);
		frm(4'hB, 4'h0, 8'h00);
		wait_idle();
		chk(lower_string_setting, 16'h807F);
		chk(flags, 16'h0000);
		frm(4'h1, 4'h0, 8'h09);
		chk(lower_string_setting, 16'h8009);
		reset_pin_n = 1'b0;
		u_host.tick(2);
		reset_pin_n = 1'b1;
		chk({15'h0, reload_busy}, 16'h0001);
		wait_idle();
		chk(lower_string_setting, 16'h807F);
		$display("test reload done");
	endtask : t_reload
	task automatic t_mode();
		power_up_mode_pin = 1'b1;
		u_host.tick(2);
		chk({15'h0, linear_mode}, 16'h0001);
		rstn = 1'b0;
		u_host.tick(16);
		rstn = 1'b1;
		wait_idle();
		chk({15'h0, linear_mode}, 16'h0001);
		chk(lower_string_setting, 16'h8080);
		chk(upper_string_setting, 16'h8080);
		// Control bit 2 is clear, so only the pin opens the upper string
		frm(4'h1, 4'h4, 8'h55);
		chk(upper_string_setting, 16'h8055);
		power_up_mode_pin = 1'b0;
		u_host.tick(2);
		chk({15'h0, linear_mode}, 16'h0000);
		$display("test mode done");
	endtask : t_mode
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	// About 9400 cycles expected; watchdog allows over three times that
	initial begin
		repeat (30000) @(posedge clk_sys);
		error_cnt++;
		finish_test();
	end
	initial begin
		u_host.tick(16);
		rstn = 1'b1;
		t_reset();
		t_write();
		t_step();
		t_nv();
		t_scale();
		t_protect();
		t_reload();
		t_mode();
		finish_test();
	end
endmodule : tb
`default_nettype wire
